//--- nbb_regs.svh
`ifndef NBB_REGS_SVH
`define NBB_REGS_SVH
// timing in ns, cycles derived at 50 MHz (20 ns)
`define NBB_CLK_NS            20
`define NBB_PAGE_LOAD_NS      12000
`define NBB_RESET_BUSY_NS     5000
`define NBB_SEQ_BUSY_NS       100
`define NBB_CE_HOLD_NS        100
`define NBB_SEL_READY_NS      50
// least times round up, longest times round down
`define NBB_CE_HOLD_CYC       ((`NBB_CE_HOLD_NS + `NBB_CLK_NS - 1) / `NBB_CLK_NS)
`define NBB_SEQ_BUSY_CYC      (`NBB_SEQ_BUSY_NS / `NBB_CLK_NS)
`define NBB_SEL_READY_CYC     (`NBB_SEL_READY_NS / `NBB_CLK_NS)
`define NBB_PAGE_LOAD_CYC     (`NBB_PAGE_LOAD_NS / `NBB_CLK_NS)
`define NBB_RESET_BUSY_CYC    (`NBB_RESET_BUSY_NS / `NBB_CLK_NS)
// bad-block marker columns
`define NBB_MARK_COL_X8       12'h205
`define NBB_MARK_COL_X16_A    12'h100
`define NBB_MARK_COL_X16_B    12'h105
`define NBB_ERASED_BYTE       16'hffff
`endif

//--- nbb_pkg.sv
`default_nettype none
package nbb_pkg;
    typedef enum logic [3:0] {
        NBB_IDLE, NBB_SCAN_REQ, NBB_SCAN_WAIT, NBB_OP_REQ, NBB_OP_WAIT,
        NBB_CE_HOLD, NBB_FAIL
    } nbb_state_t;
    typedef enum logic [1:0] {
        NBB_OP_READ, NBB_OP_PROG, NBB_OP_ERASE
    } nbb_op_t;
endpackage
`default_nettype wire

//--- nbb_ecc.sv
`timescale 1ns/1ps
`default_nettype none
// hamming code over 8 data bits plus overall parity: fix 1, detect 2
module nbb_ecc (
    // data and stored check bits
    input  wire logic [7:0] data,
    input  wire logic [4:0] check_in,
    // results
    output logic      [4:0] check_out,
    output logic      [7:0] fixed,
    output logic            single_err,
    output logic            double_err
);
    logic [12:1] cw;
    logic [3:0]  syn;
    logic        ovp;
    logic [12:1] fx;
    function automatic logic [3:0] nbb_syn(input logic [12:1] w);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 1; i <= 12; i++) begin
            if (w[i]) begin
                s = s ^ 4'(i);
            end
        end
        return s;
    endfunction
    // data at non power-of-two positions
    assign cw = {data[7:4], 1'b0, data[3:1], 1'b0, data[0], 2'b00};
    wire [3:0] gen = nbb_syn(cw);
    assign check_out = {^{data, gen}, gen};
    wire [12:1] rx = {data[7:4], check_in[3], data[3:1], check_in[2], data[0],
                      check_in[1], check_in[0]};
    assign syn = nbb_syn(rx);
    assign ovp = ^{data, check_in};
    // a double error leaves the word alone rather than flip a third bit
    assign fx = (ovp && syn != 4'h0 && syn <= 4'hc) ? rx ^ (12'h001 << (syn - 4'h1)) : rx;
    assign fixed = {fx[12:9], fx[7:5], fx[3]};
    assign single_err = ovp;
    assign double_err = !ovp && syn != 4'h0;
endmodule
`default_nettype wire

//--- nbb_host.sv
// How it works
// - end sequential read: chip select high 100 ns
// - table from factory marks, never erase them
// - program or erase of a bad block other than block 0 goes to the spare
// - failed program or erase status retires block, remap data
// - fix single-bit errors by code
// - code corrects one, detects two bits
`timescale 1ns/1ps
`default_nettype none
`include "nbb_regs.svh"
module nbb_host #(
    parameter int BLOCKS   = 8192,
    parameter int BLK_W    = 13,
    parameter int TIMEOUT  = `NBB_PAGE_LOAD_CYC + 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // user: scan start and operation request
    input  wire logic             scan_start,
    input  wire logic             op_valid,
    output logic                  op_ready,
    input  wire logic [1:0]       op_kind,
    input  wire logic [BLK_W-1:0] op_block,
    input  wire logic [7:0]       wr_data,
    input  wire logic [4:0]       rd_check,
    // user: results
    output logic                  done_r,
    output logic                  fail_r,
    output logic                  scan_busy_r,
    output logic [BLK_W-1:0]      phys_block_r,
    output logic [7:0]            rd_data_r,
    output logic [4:0]            wr_check,
    output logic                  rd_corrected_r,
    output logic                  rd_uncorrectable_r,
    // flash engine: page access requests to the pin sequencer
    output logic                  fl_req,
    output logic [1:0]            fl_kind_r,
    output logic [BLK_W-1:0]      fl_block_r,
    output logic                  fl_page1_r,
    input  wire logic             fl_ack,
    input  wire logic [15:0]      fl_mark,
    input  wire logic [7:0]       fl_data,
    input  wire logic             fl_status_fail,
    // pins watched and driven directly
    input  wire logic             ready_busy_n,
    output logic                  chip_sel_n_r
);
    nbb_pkg::nbb_state_t st_r, st_nxt;
    logic [BLOCKS-1:0]   bad_r;
    logic [BLK_W-1:0]    scan_blk_r;
    logic [BLK_W-1:0]    spare_r;
    logic [15:0]         cnt_r;
    logic                scan_pg_r;
    logic [4:0]          ecc_chk;
    logic [7:0]          ecc_fix;
    logic                ecc_s;
    logic                ecc_d;

    // remap: bad blocks other than block 0 steer to the spare pointer
    wire blk_bad    = bad_r[op_block] && op_block != '0;
    wire [BLK_W-1:0] target = blk_bad ? spare_r : op_block;
    wire is_ready   = ready_busy_n;
    wire mark_bad   = fl_mark != `NBB_ERASED_BYTE;
    wire timed_out  = cnt_r >= 16'(TIMEOUT);
    wire hold_done  = cnt_r >= 16'(`NBB_CE_HOLD_CYC);

    assign op_ready = st_r == nbb_pkg::NBB_IDLE && is_ready && !scan_busy_r;
    assign fl_req   = (st_r == nbb_pkg::NBB_SCAN_REQ || st_r == nbb_pkg::NBB_OP_REQ)
                      && is_ready;

    nbb_ecc i_nbb_ecc (
        .data       (st_r == nbb_pkg::NBB_OP_WAIT ? fl_data : wr_data),
        .check_in   (rd_check),
        .check_out  (ecc_chk),
        .fixed      (ecc_fix),
        .single_err (ecc_s),
        .double_err (ecc_d)
    );
    assign wr_check = ecc_chk;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            nbb_pkg::NBB_IDLE: begin
                if (scan_start) begin
                    st_nxt = nbb_pkg::NBB_SCAN_REQ;
                end else if (op_valid && op_ready) begin
                    st_nxt = nbb_pkg::NBB_OP_REQ;
                end
            end
            nbb_pkg::NBB_SCAN_REQ: begin
                if (fl_req) begin
                    st_nxt = nbb_pkg::NBB_SCAN_WAIT;
                end
            end
            nbb_pkg::NBB_SCAN_WAIT: begin
                if (fl_ack) begin
                    // scan ends after the last block, page 1
                    st_nxt = (scan_pg_r && scan_blk_r == BLK_W'(BLOCKS - 1))
                             ? nbb_pkg::NBB_CE_HOLD : nbb_pkg::NBB_SCAN_REQ;
                end else if (timed_out) begin
                    st_nxt = nbb_pkg::NBB_FAIL;
                end
            end
            nbb_pkg::NBB_OP_REQ: begin
                if (fl_req) begin
                    st_nxt = nbb_pkg::NBB_OP_WAIT;
                end
            end
            nbb_pkg::NBB_OP_WAIT: begin
                if (fl_ack) begin
                    st_nxt = nbb_pkg::NBB_CE_HOLD;
                end else if (timed_out) begin
                    st_nxt = nbb_pkg::NBB_FAIL;
                end
            end
            nbb_pkg::NBB_CE_HOLD: begin
                if (hold_done) begin
                    st_nxt = nbb_pkg::NBB_IDLE;
                end
            end
            nbb_pkg::NBB_FAIL:    st_nxt = nbb_pkg::NBB_CE_HOLD;
            default:              st_nxt = nbb_pkg::NBB_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_r <= nbb_pkg::NBB_IDLE;
            cnt_r <= 16'h0000;
        end else begin
            st_r <= st_nxt;
            cnt_r <= (st_nxt != st_r) ? 16'h0000 : cnt_r + 16'h0001;
        end
    end

    // chip select: high in the hold and idle states, ending a read run
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            chip_sel_n_r <= 1'b1;
        end else begin
            chip_sel_n_r <= st_nxt == nbb_pkg::NBB_CE_HOLD
                            || st_nxt == nbb_pkg::NBB_IDLE;
        end
    end

    // request fields
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fl_kind_r <= 2'h0;
            fl_block_r <= '0;
            fl_page1_r <= 1'b0;
        end else if (st_r == nbb_pkg::NBB_IDLE && st_nxt == nbb_pkg::NBB_OP_REQ) begin
            fl_kind_r <= op_kind;
            fl_block_r <= target;
            fl_page1_r <= 1'b0;
        end else if (st_nxt == nbb_pkg::NBB_SCAN_REQ) begin
            // scan reads only, never erases the markers
            fl_kind_r <= nbb_pkg::NBB_OP_READ;
            fl_block_r <= st_r == nbb_pkg::NBB_IDLE ? '0 :
                          (scan_pg_r ? scan_blk_r + BLK_W'(1) : scan_blk_r);
            fl_page1_r <= st_r == nbb_pkg::NBB_IDLE ? 1'b0 : !scan_pg_r;
        end
    end

    // scan walk and bad-block table
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scan_blk_r <= '0;
            scan_pg_r <= 1'b0;
            scan_busy_r <= 1'b0;
            bad_r <= '0;
            spare_r <= BLK_W'(BLOCKS - 1);
        end else begin
            if (st_r == nbb_pkg::NBB_IDLE && scan_start) begin
                scan_busy_r <= 1'b1;
                scan_blk_r <= '0;
                scan_pg_r <= 1'b0;
                bad_r <= '0;
            end
            if (st_r == nbb_pkg::NBB_SCAN_WAIT && fl_ack) begin
                if (mark_bad) begin
                    bad_r[fl_block_r] <= 1'b1;
                end
                scan_pg_r <= !scan_pg_r;
                if (scan_pg_r) begin
                    scan_blk_r <= scan_blk_r + BLK_W'(1);
                end
            end
            if (st_r == nbb_pkg::NBB_CE_HOLD && hold_done) begin
                scan_busy_r <= 1'b0;
            end
            // failed program or erase: retire block, next spare goes down
            if (st_r == nbb_pkg::NBB_OP_WAIT && fl_ack && fl_status_fail
                && fl_kind_r != nbb_pkg::NBB_OP_READ) begin
                bad_r[fl_block_r] <= 1'b1;
                spare_r <= spare_r - BLK_W'(1);
            end
        end
    end

    // results
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            phys_block_r <= '0;
            rd_data_r <= 8'h00;
            rd_corrected_r <= 1'b0;
            rd_uncorrectable_r <= 1'b0;
        end else begin
            done_r <= st_r == nbb_pkg::NBB_OP_WAIT && fl_ack;
            fail_r <= (st_r == nbb_pkg::NBB_OP_WAIT && fl_ack && fl_status_fail)
                      || st_r == nbb_pkg::NBB_FAIL;
            if (st_r == nbb_pkg::NBB_OP_WAIT && fl_ack) begin
                phys_block_r <= fl_block_r;
                rd_data_r <= ecc_fix;
                rd_corrected_r <= ecc_s;
                rd_uncorrectable_r <= ecc_d;
            end
        end
    end

    // a busy device holds the request states where they are
    property p_no_req_busy;
        @(posedge clock) disable iff (!rst_b)
        ((st_r == nbb_pkg::NBB_SCAN_REQ || st_r == nbb_pkg::NBB_OP_REQ) && !ready_busy_n)
        |=> st_r == $past(st_r);
    endproperty
    a_no_req_busy: assert property (p_no_req_busy) else $error("request while busy");

    property p_hold_len;
        @(posedge clock) disable iff (!rst_b)
        $rose(st_r == nbb_pkg::NBB_CE_HOLD) |-> chip_sel_n_r [*5];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("select hold too short");

    property p_remap;
        @(posedge clock) disable iff (!rst_b)
        (st_r == nbb_pkg::NBB_OP_REQ && fl_kind_r != nbb_pkg::NBB_OP_READ)
        |-> !bad_r[fl_block_r] || fl_block_r == '0;
    endproperty
    a_remap: assert property (p_remap) else $error("write to bad block");

    property p_retire;
        @(posedge clock) disable iff (!rst_b)
        (st_r == nbb_pkg::NBB_OP_WAIT && fl_ack && fl_status_fail
         && fl_kind_r != nbb_pkg::NBB_OP_READ) |=> bad_r[$past(fl_block_r)] && fail_r;
    endproperty
    a_retire: assert property (p_retire) else $error("failed block not retired");

    property p_scan_read;
        @(posedge clock) disable iff (!rst_b)
        (st_r == nbb_pkg::NBB_SCAN_WAIT) |-> fl_kind_r == nbb_pkg::NBB_OP_READ;
    endproperty
    a_scan_read: assert property (p_scan_read) else $error("scan not a read");

    property p_mark;
        @(posedge clock) disable iff (!rst_b)
        (st_r == nbb_pkg::NBB_SCAN_WAIT && fl_ack && fl_mark != 16'hffff)
        |=> bad_r[$past(fl_block_r)];
    endproperty
    a_mark: assert property (p_mark) else $error("marker missed");

    // a word paired with its own check bits must decode clean
    property p_ecc;
        @(posedge clock) disable iff (!rst_b)
        (st_r != nbb_pkg::NBB_OP_WAIT && rd_check == ecc_chk) |-> !ecc_s && !ecc_d;
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc flags clash");

    property p_timeout;
        @(posedge clock) disable iff (!rst_b)
        (st_r == nbb_pkg::NBB_OP_WAIT && !fl_ack && timed_out) |=> st_r == nbb_pkg::NBB_FAIL;
    endproperty
    a_timeout: assert property (p_timeout) else $error("page load overrun missed");
endmodule
`default_nettype wire

//--- nbb_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// flash device behind the page access port; only no_ack, stall and fail_blk make it misbehave
module nbb_flash_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // page access port
    input  wire logic        fl_req,
    input  wire logic [1:0]  fl_kind_r,
    input  wire logic [2:0]  fl_block_r,
    input  wire logic        fl_page1_r,
    input  wire logic        chip_sel_n_r,
    output logic             fl_ack,
    output logic [15:0]      fl_mark,
    output logic [7:0]       fl_data,
    output logic             fl_status_fail,
    output logic             ready_busy_n,
    // bench control
    input  wire logic [5:0]  load_cyc,
    input  wire logic        no_ack,
    input  wire logic        stall,
    input  wire logic [2:0]  fail_blk,
    output int               viol,
    output int               takes
);
    logic [5:0]  cnt_r;
    logic [7:0]  rst_cnt_r;
    logic        busy_r;
    logic [15:0] mark_r;
    logic        sfail_r;
    // factory marks on block 2 page 0 and block 4 page 1; block 0 kept good
    wire         mark2    = fl_block_r == 3'h2 && !fl_page1_r;
    wire         mark4    = fl_block_r == 3'h4 && fl_page1_r;
    wire  [15:0] mark_now = mark2 ? 16'h00a5 : (mark4 ? 16'h5aff : 16'hffff);
    wire         take     = fl_req && ready_busy_n && !no_ack;
    wire         bad_req  = take && fl_kind_r != 2'h0 && (fl_block_r == 3'h2 || fl_block_r == 3'h4);
    wire         busy_req = fl_req && !ready_busy_n;
    assign ready_busy_n = !(busy_r || stall || rst_cnt_r != 8'h00);
    // released bus shows the inverse, so a late sample cannot pass by luck
    assign fl_mark = fl_ack ? mark_r : ~mark_r;
    assign fl_data = fl_ack ? 8'hff : 8'h00;
    assign fl_status_fail = fl_ack ? sfail_r : ~sfail_r;
    always_ff @(posedge clock) begin
        fl_ack <= 1'b0;
        if (!rst_b) begin
            busy_r <= 1'b0;
            cnt_r <= 6'h00;
            // reset behaves like a reset command given while ready: a short busy spell
            rst_cnt_r <= 8'h0a;
            viol <= 0;
            takes <= 0;
        end else begin
            if (rst_cnt_r != 8'h00) begin
                rst_cnt_r <= rst_cnt_r - 8'h01;
            end
            if (take) begin
                busy_r <= 1'b1;
                cnt_r <= load_cyc;
                mark_r <= mark_now;
                sfail_r <= (fl_kind_r == 2'h1) && (fl_block_r == fail_blk);
                takes <= takes + 1;
            end else if (busy_r && chip_sel_n_r) begin
                // deselected mid load: back to ready at once, no data handed over
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 6'h01;
                if (cnt_r == 6'h00) begin
                    busy_r <= 1'b0;
                    fl_ack <= 1'b1;
                end
            end
            viol <= viol + int'(bad_req) + int'(busy_req);
        end
    end
endmodule
`default_nettype wire

//--- nbb_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nbb_host_tb;
    typedef struct {logic f; logic [2:0] b; logic r; logic [7:0] d; logic c; logic u;} nbb_note_t;
    logic        clock, rst_b, scan_start, op_valid, no_ack, stall, in_scan;
    logic [1:0]  op_kind;
    logic [2:0]  op_block, fail_blk, phys_block_r, fl_block_r;
    logic [7:0]  wr_data, rd_data_r, fl_data;
    logic [4:0]  rd_check, wr_check;
    logic [5:0]  load_cyc;
    logic [15:0] fl_mark;
    logic        op_ready, done_r, fail_r, scan_busy_r, rd_corrected_r, rd_uncorrectable_r;
    logic        fl_req, fl_page1_r, fl_ack, fl_status_fail, ready_busy_n, chip_sel_n_r;
    logic [1:0]  fl_kind_r;
    int          err_total, checks, cyc, viol, takes;
    nbb_note_t   notes[$];
    nbb_host #(.BLOCKS(8), .BLK_W(3), .TIMEOUT(100)) i_nbb_host (.clock(clock), .rst_b(rst_b),
        .scan_start(scan_start), .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
        .op_block(op_block), .wr_data(wr_data), .rd_check(rd_check), .done_r(done_r),
        .fail_r(fail_r), .scan_busy_r(scan_busy_r), .phys_block_r(phys_block_r),
        .rd_data_r(rd_data_r), .wr_check(wr_check), .rd_corrected_r(rd_corrected_r),
        .rd_uncorrectable_r(rd_uncorrectable_r), .fl_req(fl_req), .fl_kind_r(fl_kind_r),
        .fl_block_r(fl_block_r), .fl_page1_r(fl_page1_r), .fl_ack(fl_ack), .fl_mark(fl_mark),
        .fl_data(fl_data), .fl_status_fail(fl_status_fail), .ready_busy_n(ready_busy_n),
        .chip_sel_n_r(chip_sel_n_r));
    nbb_flash_model i_nbb_flash_model (.clock(clock), .rst_b(rst_b), .fl_req(fl_req),
        .chip_sel_n_r(chip_sel_n_r),
        .fl_kind_r(fl_kind_r), .fl_block_r(fl_block_r), .fl_page1_r(fl_page1_r),
        .fl_ack(fl_ack), .fl_mark(fl_mark), .fl_data(fl_data), .fl_status_fail(fl_status_fail),
        .ready_busy_n(ready_busy_n), .load_cyc(load_cyc), .no_ack(no_ack), .stall(stall),
        .fail_blk(fail_blk), .viol(viol), .takes(takes));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic stop_test;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic cmp_blk(input logic [2:0] got, input logic [2:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask
    // one request, then wait until the watcher has consumed its note
    // check bits: ff encodes as 03, fe as 10; ff read with 10 is fe with one bit off,
    // ff read with 00 has two bits off
    task automatic do_op(input logic [1:0] k, input logic [2:0] b, input logic f,
                         input logic [2:0] p);
        int n;
        int sel;
        nbb_note_t e;
        logic [7:0] wd;
        sel = $urandom_range(0, 2);
        wd = 8'hff ^ 8'($urandom_range(0, 1));
        e.f = f;
        e.b = p;
        e.r = k == 2'h0;
        e.d = sel == 1 ? 8'hfe : 8'hff;
        e.c = sel == 1;
        e.u = sel == 2;
        op_valid <= 1'b1;
        op_kind <= k;
        op_block <= b;
        wr_data <= wd;
        rd_check <= sel == 0 ? 5'h03 : (sel == 1 ? 5'h10 : 5'h00);
        load_cyc <= 6'($urandom_range(2, 40));
        notes.push_back(e);
        @(posedge clock);
        for (n = 0; n < 300 && op_ready !== 1'b1; n++) @(posedge clock);
        cmp_byte(8'(wr_check), wd == 8'hff ? 8'h03 : 8'h10, "write check bits");
        op_valid <= 1'b0;
        for (n = 0; n < 400 && notes.size() > 0; n++) @(posedge clock);
        cmp_bit(notes.size() == 0, 1'b1, "no result");
        repeat (3) begin
            @(posedge clock);
            cmp_bit(op_ready, 1'b0, "request taken during select hold");
        end
        repeat (4) @(posedge clock);
    endtask
    always @(posedge clock) begin
        nbb_note_t n;
        if (rst_b && !in_scan && (done_r || fail_r)) begin
            if (notes.size() == 0) cmp_bit(1'b1, 1'b0, "unexpected result");
            else begin
                n = notes.pop_front();
                cmp_bit(fail_r, n.f, "fail flag");
                cmp_bit(chip_sel_n_r, 1'b1, "select not released");
                if (!n.f) cmp_blk(phys_block_r, n.b, "physical block");
                if (!n.f && n.r) begin
                    cmp_bit(rd_corrected_r, n.c, "corrected flag");
                    cmp_bit(rd_uncorrectable_r, n.u, "uncorrectable flag");
                    if (!n.u) cmp_byte(rd_data_r, n.d, "read data");
                end
            end
        end
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end
    initial begin
        int k;
        logic [2:0] rb;
        {rst_b, scan_start, op_valid, no_ack, stall, op_kind, op_block} = '0;
        {wr_data, rd_check, fail_blk, load_cyc} = '0;
        {err_total, checks, cyc} = '0;
        in_scan = 1'b1;
        void'($urandom(66557));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        load_cyc <= 6'($urandom_range(2, 40));
        @(posedge clock);
        scan_start <= 1'b1;
        @(posedge clock);
        scan_start <= 1'b0;
        repeat (2) @(posedge clock);
        for (k = 0; k < 3000 && scan_busy_r !== 1'b0; k++) @(posedge clock);
        cmp_bit(takes == 16, 1'b1, "scan page count");
        repeat (8) @(posedge clock);
        in_scan = 1'b0;
        fail_blk <= 3'h1;
        // every bad block but block 0 steers to the one spare, which moves down only after a failure
        do_op(2'h1, 3'h2, 1'b0, 3'h7);
        do_op(2'h2, 3'h4, 1'b0, 3'h7);
        do_op(2'h0, 3'h0, 1'b0, 3'h0);
        do_op(2'h1, 3'h1, 1'b1, 3'h1);
        do_op(2'h0, 3'h1, 1'b0, 3'h6);
        for (k = 0; k < 9; k++) begin
            rb = 3'($urandom_range(0, 1) * 3);
            do_op(2'(k % 3), rb, 1'b0, rb);
        end
        stall <= 1'b1;
        repeat (2) @(posedge clock);
        repeat (20) begin
            @(posedge clock);
            cmp_bit(op_ready, 1'b0, "ready while busy");
        end
        stall <= 1'b0;
        do_op(2'h0, 3'h3, 1'b0, 3'h3);
        no_ack <= 1'b1;
        do_op(2'h0, 3'h3, 1'b1, 3'h3);
        no_ack <= 1'b0;
        cmp_bit(viol == 0, 1'b1, "model saw a forbidden request");
        stop_test;
    end
endmodule
`default_nettype wire
